/* logic/terminal_map_params.svh */
// constants for the contact input function mapper
`ifndef TERMINAL_MAP_PARAMS_SVH
`define TERMINAL_MAP_PARAMS_SVH

// control clock and contact debounce timing
`define CLK_PERIOD_NS 100
`define DEBOUNCE_TIME_US 1000
`define DEBOUNCE_CYCLES_DFLT ((`DEBOUNCE_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// input function codes
`define FN_NONE 7'h00
`define FN_STANDBY 7'h01
`define FN_FWD 7'h02
`define FN_REV 7'h03
`define FN_JOG 7'h04
`define FN_RAMP2 7'h05
`define FN_PRESET0 7'h06
`define FN_RESET 7'h0a
`define FN_MAX 7'h4b

// function codes after reset
`define CODE0_RST 7'h02
`define CODE1_RST 7'h03
`define CODE2_RST 7'h00
`define CODE3_RST 7'h0a
`define DUAL_CODE_RST 7'h00

// configuration write indices
`define CFG_IDX_DUAL_CODE 3'h4
`define CFG_IDX_DUAL_MODE 3'h5
`define DUAL_MODE_MAX 2'h2

// channel layout
`define NUM_CH 5
`define DUAL_CH 4
`define NUM_PRESET_BITS 4

`endif

/* logic/terminal_map_pkg.sv */
// types for the contact input function mapper
package terminal_map_pkg;
	typedef logic [6:0] func_code_t;
	typedef enum logic [1:0] {
		DUAL_ANALOG,
		DUAL_SINK,
		DUAL_SOURCE
	} dual_mode_e;
endpackage

/* logic/input_terminal_function_mapper.sv */
// maps contact inputs onto run, standby, jog, ramp, preset and reset commands
`timescale 1ns/1ns
`include "terminal_map_params.svh"

module input_terminal_function_mapper import terminal_map_pkg::*; #(
	parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES_DFLT
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// contact pins, asynchronous to clk
	input wire logic contact_in0,
	input wire logic contact_in1,
	input wire logic contact_in2,
	input wire logic contact_in3,
	input wire logic dual_purpose_input,
	// configuration writes from software or keypad
	input wire logic cfg_write,
	input wire logic [2:0] cfg_index,
	input wire logic [6:0] cfg_value,
	// operating mode
	input wire logic three_wire_mode,
	// current configuration
	output logic [6:0] contact_in0_function_code,
	output logic [6:0] contact_in1_function_code,
	output logic [6:0] contact_in2_function_code,
	output logic [6:0] contact_in3_function_code,
	output logic [6:0] dual_input_function_code,
	output logic [1:0] dual_input_mode_select,
	// commands to the drive
	output logic ready_q,
	output logic coast_stop_q,
	output logic run_fwd_q,
	output logic run_rev_q,
	output logic slowdown_stop_q,
	output logic jog_run_q,
	output logic ramp2_select_q,
	output logic [3:0] preset_speed_q,
	output logic preset_active_q,
	output logic reset_armed_q,
	output logic trip_reset_q
);

	localparam int CNT_W = $clog2(DEBOUNCE_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DEBOUNCE_CYCLES - 1);

	// mask of channels that carry a given function code
	function automatic logic [`NUM_CH-1:0] match(input func_code_t [`NUM_CH-1:0] codes,
			input func_code_t fn);
		logic [`NUM_CH-1:0] m;
		m = '0;
		for (int i = 0; i < `NUM_CH; i++) begin
			m[i] = (codes[i] == fn);
		end
		return m;
	endfunction

	// configuration group
	func_code_t [`NUM_CH-1:0] code_q, code_d;
	dual_mode_e mode_q, mode_d;

	// out-of-range values are dropped so a bad write cannot leave an undefined code
	always_comb begin
		code_d = code_q;
		mode_d = mode_q;
		if (cfg_write) begin
			if (cfg_index < 3'(`NUM_CH) && cfg_value <= `FN_MAX) begin
				code_d[cfg_index] = cfg_value;
			end
			if (cfg_index == `CFG_IDX_DUAL_MODE && cfg_value[1:0] <= `DUAL_MODE_MAX
					&& cfg_value[6:2] == 5'h00) begin
				mode_d = dual_mode_e'(cfg_value[1:0]);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			code_q[0] <= `CODE0_RST;
			code_q[1] <= `CODE1_RST;
			code_q[2] <= `CODE2_RST;
			code_q[3] <= `CODE3_RST;
			code_q[`DUAL_CH] <= `DUAL_CODE_RST;
			mode_q <= DUAL_ANALOG;
		end else begin
			code_q <= code_d;
			mode_q <= mode_d;
		end
	end

	assign contact_in0_function_code = code_q[0];
	assign contact_in1_function_code = code_q[1];
	assign contact_in2_function_code = code_q[2];
	assign contact_in3_function_code = code_q[3];
	assign dual_input_function_code = code_q[`DUAL_CH];
	assign dual_input_mode_select = mode_q;

	// synchroniser and debounce group
	logic [`NUM_CH-1:0] pins;
	logic [`NUM_CH-1:0] sync1_q, sync2_q, deb_q, deb_d;
	logic [CNT_W-1:0] cnt_q [`NUM_CH];
	logic [CNT_W-1:0] cnt_d [`NUM_CH];

	assign pins = {dual_purpose_input, contact_in3, contact_in2, contact_in1, contact_in0};

	// debounce filter
	// a level must hold for the full window before it is taken; chatter restarts the count
	always_comb begin
		deb_d = deb_q;
		for (int i = 0; i < `NUM_CH; i++) begin
			cnt_d[i] = '0;
			if (sync2_q[i] != deb_q[i]) begin
				if (cnt_q[i] == CNT_LAST) begin
					deb_d[i] = sync2_q[i];
				end else begin
					cnt_d[i] = cnt_q[i] + CNT_W'(1);
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			sync1_q <= '0;
			sync2_q <= '0;
			deb_q <= '0;
			for (int i = 0; i < `NUM_CH; i++) begin
				cnt_q[i] <= '0;
			end
		end else begin
			sync1_q <= pins;
			sync2_q <= sync1_q;
			deb_q <= deb_d;
			cnt_q <= cnt_d;
		end
	end

	// active levels and edges
	logic [`NUM_CH-1:0] lvl, prev_q, chan_en, rise, fall;

	// sink inputs are active low, source inputs active high; analog mode has no contact
	always_comb begin
		lvl = deb_q;
		lvl[`DUAL_CH] = (mode_q == DUAL_SINK) ? ~deb_q[`DUAL_CH] : deb_q[`DUAL_CH];
		chan_en = '1;
		chan_en[`DUAL_CH] = (mode_q != DUAL_ANALOG);
	end

	assign rise = lvl & ~prev_q;
	assign fall = ~lvl & prev_q;

	// per-function views; codes 0 and 11..75 match nothing here, so they stay inert
	logic [`NUM_CH-1:0] m_stby, m_fwd, m_rev, m_jog, m_ramp, m_rst;
	assign m_stby = match(code_q, `FN_STANDBY) & chan_en;
	assign m_fwd = match(code_q, `FN_FWD) & chan_en;
	assign m_rev = match(code_q, `FN_REV) & chan_en;
	assign m_jog = match(code_q, `FN_JOG) & chan_en;
	assign m_ramp = match(code_q, `FN_RAMP2) & chan_en;
	assign m_rst = match(code_q, `FN_RESET) & chan_en;

	// command group
	logic ready_d, coast_d, fwd_d, rev_d, slow_d, jog_d, ramp2_d;
	logic [3:0] preset_d;
	logic preset_act_d, armed_d, trip_reset_d;
	logic fwd_on, rev_on;

	always_comb begin
		fwd_on = |(m_fwd & lvl);
		rev_on = |(m_rev & lvl);
		// standby gate
		// with no standby input assigned the drive stays ready
		coast_d = |(m_stby & ~lvl);
		ready_d = ~coast_d;
		if (!three_wire_mode) begin
			// forward and reverse level run
			// both directions held together is treated as a stop
			fwd_d = fwd_on & ~rev_on;
			rev_d = rev_on & ~fwd_on;
		end else begin
			fwd_d = run_fwd_q;
			rev_d = run_rev_q;
			// forward and reverse start edge
			// an edge in the other direction reverses; simultaneous edges keep state
			if (|(m_fwd & rise) && !(|(m_rev & rise))) begin
				fwd_d = 1'b1;
				rev_d = 1'b0;
			end else if (|(m_rev & rise) && !(|(m_fwd & rise))) begin
				fwd_d = 1'b0;
				rev_d = 1'b1;
			end
		end
		if (coast_d) begin
			fwd_d = 1'b0;
			rev_d = 1'b0;
		end
		slow_d = (run_fwd_q | run_rev_q) & ~(fwd_d | rev_d) & ~coast_d;
		jog_d = |(m_jog & lvl) & ~coast_d;
		ramp2_d = |(m_ramp & lvl);
		for (int b = 0; b < `NUM_PRESET_BITS; b++) begin
			preset_d[b] = |(match(code_q, `FN_PRESET0 + 7'(b)) & chan_en & lvl);
		end
		preset_act_d = |preset_d;
		armed_d = |(m_rst & lvl);
		trip_reset_d = |(m_rst & fall);
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			prev_q <= '0;
			ready_q <= 1'b0;
			coast_stop_q <= 1'b1;
			run_fwd_q <= 1'b0;
			run_rev_q <= 1'b0;
			slowdown_stop_q <= 1'b0;
			jog_run_q <= 1'b0;
			ramp2_select_q <= 1'b0;
			preset_speed_q <= 4'h0;
			preset_active_q <= 1'b0;
			reset_armed_q <= 1'b0;
			trip_reset_q <= 1'b0;
		end else begin
			prev_q <= lvl;
			ready_q <= ready_d;
			coast_stop_q <= coast_d;
			run_fwd_q <= fwd_d;
			run_rev_q <= rev_d;
			slowdown_stop_q <= slow_d;
			jog_run_q <= jog_d;
			ramp2_select_q <= ramp2_d;
			preset_speed_q <= preset_d;
			preset_active_q <= preset_act_d;
			reset_armed_q <= armed_d;
			trip_reset_q <= trip_reset_d;
		end
	end

endmodule

/* dv/terminal_map_props.sv */
// concurrent checks on the contact input function mapper ports
`timescale 1ns/1ns
module terminal_map_props (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// configuration
	input wire logic cfg_write,
	input wire logic [2:0] cfg_index,
	input wire logic [6:0] cfg_value,
	input wire logic [6:0] contact_in2_function_code,
	// commands
	input wire logic ready_q,
	input wire logic coast_stop_q,
	input wire logic run_fwd_q,
	input wire logic run_rev_q,
	input wire logic jog_run_q,
	input wire logic slowdown_stop_q,
	input wire logic [3:0] preset_speed_q,
	input wire logic preset_active_q,
	input wire logic reset_armed_q,
	input wire logic trip_reset_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// any run direction, used to judge a slowdown pulse
	wire running = run_fwd_q | run_rev_q;
	sequence s_arm_drop;
		$past(reset_armed_q) && !reset_armed_q;
	endsequence
	property p_cfg_take;
		cfg_write && cfg_index == 3'h2 && cfg_value <= 7'h4b
			|=> contact_in2_function_code == $past(cfg_value);
	endproperty
	property p_cfg_refuse;
		cfg_write && cfg_value > 7'h4b |=> $stable(contact_in2_function_code);
	endproperty
	property p_ready_coast;
		ready_q != coast_stop_q;
	endproperty
	property p_coast_halts;
		coast_stop_q |-> !run_fwd_q && !run_rev_q && !jog_run_q;
	endproperty
	property p_dir_excl;
		!(run_fwd_q && run_rev_q);
	endproperty
	property p_slow_cause;
		slowdown_stop_q |-> $past(running) && !running ##1 !slowdown_stop_q;
	endproperty
	property p_trip_cause;
		trip_reset_q |-> s_arm_drop ##1 !trip_reset_q;
	endproperty
	property p_preset_flag;
		preset_active_q == (preset_speed_q != 4'h0);
	endproperty
	a_cfg_take: assert property (p_cfg_take) else $error("code write not taken");
	a_cfg_refuse: assert property (p_cfg_refuse) else $error("bad code accepted");
	a_ready_coast: assert property (p_ready_coast) else $error("ready and coast agree");
	a_coast_halts: assert property (p_coast_halts) else $error("run during coast");
	a_dir_excl: assert property (p_dir_excl) else $error("both directions");
	a_slow_cause: assert property (p_slow_cause) else $error("bad slowdown pulse");
	a_trip_cause: assert property (p_trip_cause) else $error("bad trip reset pulse");
	a_preset_flag: assert property (p_preset_flag) else $error("preset flag wrong");
endmodule
bind input_terminal_function_mapper terminal_map_props u_props (.clk(clk), .rstn(rstn),
	.cfg_write(cfg_write), .cfg_index(cfg_index), .cfg_value(cfg_value),
	.contact_in2_function_code(contact_in2_function_code), .ready_q(ready_q),
	.coast_stop_q(coast_stop_q), .run_fwd_q(run_fwd_q), .run_rev_q(run_rev_q),
	.jog_run_q(jog_run_q), .slowdown_stop_q(slowdown_stop_q), .preset_speed_q(preset_speed_q),
	.preset_active_q(preset_active_q), .reset_armed_q(reset_armed_q),
	.trip_reset_q(trip_reset_q));

/* dv/contact_ctl_model.sv */
// far-side controller model driving the contact pins
`timescale 1ns/1ns
module contact_ctl_model (
	// control clock
	input wire logic clk,
	// contact levels, bit 4 is the dual-purpose input
	output logic [4:0] pins
);
	initial pins = 5'h00;
	// changes land on the falling edge, clear of the sampling edge
	task put(input int i, input logic v);
		@(negedge clk);
		pins[i] = v;
	endtask
endmodule

/* dv/tb_input_terminal_function_mapper.sv */
// self-checking bench for the contact input function mapper
`timescale 1ns/1ns
module tb_input_terminal_function_mapper;
	localparam int D = 4;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic cfg_write = 1'b0;
	logic [2:0] cfg_index = 3'h0;
	logic [6:0] cfg_value = 7'h00;
	logic three_wire_mode = 1'b0;
	logic [4:0] pins;
	logic [6:0] c0, c1, c2, c3, dc;
	logic [1:0] dm;
	logic rdy, coast, fwd, rev, slow, jog, ramp2, pact, armed, trip;
	logic [3:0] preset;
	int failures = 0;
	int samples_checked = 0;
	int slow_n = 0;
	int trip_n = 0;
	// 10 MHz control clock
	always #50 clk = ~clk;
	// count one-cycle pulses, so a missed or doubled pulse shows
	always @(posedge clk) begin
		slow_n <= slow_n + (slow === 1'b1);
		trip_n <= trip_n + (trip === 1'b1);
	end
	contact_ctl_model drv (.clk(clk), .pins(pins));
	input_terminal_function_mapper #(.DEBOUNCE_CYCLES(D)) uut (.clk(clk), .rstn(rstn),
		.contact_in0(pins[0]), .contact_in1(pins[1]), .contact_in2(pins[2]),
		.contact_in3(pins[3]), .dual_purpose_input(pins[4]), .cfg_write(cfg_write),
		.cfg_index(cfg_index), .cfg_value(cfg_value), .three_wire_mode(three_wire_mode),
		.contact_in0_function_code(c0), .contact_in1_function_code(c1),
		.contact_in2_function_code(c2), .contact_in3_function_code(c3),
		.dual_input_function_code(dc), .dual_input_mode_select(dm), .ready_q(rdy),
		.coast_stop_q(coast), .run_fwd_q(fwd), .run_rev_q(rev), .slowdown_stop_q(slow),
		.jog_run_q(jog), .ramp2_select_q(ramp2), .preset_speed_q(preset),
		.preset_active_q(pact), .reset_armed_q(armed), .trip_reset_q(trip));
	task chk(input string n, input logic [6:0] e, input logic [6:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task cfg(input logic [2:0] i, input logic [6:0] v);
		@(negedge clk);
		cfg_write = 1'b1;
		cfg_index = i;
		cfg_value = v;
		@(negedge clk);
		cfg_write = 1'b0;
	endtask
	// sync plus debounce plus register, with margin for sample phase
	task wt();
		repeat (D + 6) @(negedge clk);
	endtask
	task t_two_wire();
		int n;
		drv.put(0, 1'b1);
		drv.put(0, 1'b0);
		wt();
		chk("glitch", 7'h00, fwd);
		drv.put(0, 1'b1);
		wt();
		chk("fwd", 7'h01, fwd);
		n = slow_n;
		drv.put(0, 1'b0);
		wt();
		chk("slow", 7'h01, 7'(slow_n - n));
		drv.put(1, 1'b1);
		wt();
		chk("rev", 7'h01, rev);
		drv.put(1, 1'b0);
		drv.put(3, 1'b1);
		wt();
		chk("armed", 7'h01, armed);
		n = trip_n;
		drv.put(3, 1'b0);
		wt();
		chk("trip", 7'h01, 7'(trip_n - n));
	endtask
	task t_three_wire();
		@(negedge clk);
		three_wire_mode = 1'b1;
		drv.put(0, 1'b1);
		wt();
		drv.put(0, 1'b0);
		wt();
		chk("fwd3", 7'h01, fwd);
		drv.put(1, 1'b1);
		wt();
		chk("rev3", 7'h02, {rev, fwd});
		drv.put(1, 1'b0);
		three_wire_mode = 1'b0;
		wt();
		chk("stop3", 7'h00, {rev, fwd});
	endtask
	task t_functions();
		cfg(3'h2, 7'h04);
		drv.put(2, 1'b1);
		wt();
		chk("jog", 7'h01, jog);
		cfg(3'h2, 7'h05);
		wt();
		chk("ramp2", 7'h01, {jog, ramp2});
		cfg(3'h2, 7'h00);
		wt();
		chk("none", 7'h01, {jog, ramp2, rdy});
		cfg(3'h2, 7'h01);
		drv.put(0, 1'b1);
		drv.put(2, 1'b0);
		wt();
		chk("coast", 7'h01, {rdy, coast});
		chk("coast_run", 7'h00, fwd);
		cfg(3'h2, 7'h4c);
		cfg(3'h6, 7'h00);
		chk("refuse", 7'h01, c2);
		cfg(3'h2, 7'h4b);
		chk("max", 7'h4b, c2);
		cfg(3'h4, 7'h05);
		cfg(3'h5, 7'h02);
		drv.put(4, 1'b1);
		wt();
		chk("source", 7'h01, ramp2);
		cfg(3'h5, 7'h01);
		wt();
		chk("sink", 7'h00, ramp2);
		cfg(3'h5, 7'h00);
		wt();
		chk("analog", 7'h00, ramp2);
		drv.put(4, 1'b0);
		drv.put(0, 1'b0);
		wt();
	endtask
	task t_preset();
		for (int i = 0; i < 4; i++) cfg(3'(i), 7'(6 + i));
		drv.put(1, 1'b1);
		drv.put(3, 1'b1);
		wt();
		chk("preset", 7'h1a, {pact, preset});
		drv.put(1, 1'b0);
		drv.put(3, 1'b0);
		wt();
		chk("nopreset", 7'h00, {pact, preset});
	endtask
	task wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// cut a hang short well past the expected few hundred cycles
	initial begin
		#500000;
		failures++;
		wrap_up();
	end
	initial begin
		repeat (16) @(negedge clk);
		rstn = 1'b1;
		@(negedge clk);
		chk("codes", 7'h7f, {c0 === 7'h02, c1 === 7'h03, c2 === 7'h00, c3 === 7'h0a,
			dc === 7'h00, dm === 2'h0, rdy === 1'b1});
		t_two_wire();
		t_three_wire();
		t_functions();
		t_preset();
		wrap_up();
	end
endmodule
